// ### hw/nfc_irq_status_collision_pos.sv
// Interrupt status, enable and collision position registers
//
// Notes on behaviour
// [R1] Status resets to zero and is cleared when a read of it completes.
// [R2] Transmit flag bit 7 sets at transmit start; interrupt waits for end.
// [R3] Receive flag bit 6 sets at start of frame; interrupt waits for end.
// [R4] FIFO flag bit 5 sets when the fill level crosses a threshold.
// [R5] In NFC or card emulation bit 3 marks SDD done and bit 4 any error.
// [R6] In NFC or card emulation bit 2 sets on each field level change outside a transfer phase.
// [R7] In NFC bit 1 sets once avoidance is done and the wait has elapsed.
// [R8] In NFC bit 0 reports avoidance blocked by an external field.
// [R9] Enables for FIFO, CRC, parity and collision sit at 5,4,3,1, reset 1.
// [R10] Framing enable at bit 2 resets to 1, no-response at bit 0 to 0.
// [R11] Enable bits 7 and 6 show position bits 9 and 8 for Type A.
// [R12] Position register shows the low eight bits of the collision.
// [R13] Outside Type A the position register records an error position.
// [R14] Position clears at reset, while enable is low, and after a read.
// [R15] A status read clears the flags and the interrupt line together.
// [R16] Transmit may set only bits 5 and 7, receive only bit 6.
// [R17] The interrupt is asserted only for bits 7 and 6 or for a flag whose enable is set.
`timescale 1ns/100ps
`include "nfc_irq_cfg.svh"

module nfc_irq_status_collision_pos
  import nfc_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire wb_req_t wb_req,
  output wb_rsp_t wb_rsp,
  input wire op_mode_t op_mode,
  input wire logic chip_en,
  input wire logic type_a,
  input wire nfc_evt_t evt,
  input wire logic field_ok,
  input wire logic [9:0] col_bit_pos,
  input wire logic [9:0] err_bit_pos,
  output logic irq
);

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_TX,
    PH_RX
  } phase_t;

  localparam logic [7:0] CA_WAIT = 8'(`CA_WAIT_CYC);

  function automatic reg_id_t reg_hit(input logic [31:0] adr);
    reg_id_t id;
    id = REG_NONE;
    if (adr == {22'h0, `IRQ_STATUS_IDX, 2'b00}) begin
      id = REG_STATUS;
    end else if (adr == {22'h0, `IRQ_ENABLE_IDX, 2'b00}) begin
      id = REG_ENABLE;
    end else if (adr == {22'h0, `COL_POS_IDX, 2'b00}) begin
      id = REG_COLPOS;
    end
    return id;
  endfunction

  // Mask of flags that may be set in a transfer phase
  function automatic logic [7:0] phase_allow(input phase_t ph);
    logic [7:0] m;
    m = `IDLE_ALLOW;
    unique case (ph)
      PH_TX: m = `TX_ALLOW; // [R16]
      PH_RX: m = `RX_ALLOW; // [R16]
      PH_IDLE: m = `IDLE_ALLOW;
      default: m = `IDLE_ALLOW;
    endcase
    return m;
  endfunction

  // Bus slave state
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic rd_done, wr_done;
  logic st_clr, cp_clr, en_wr;
  reg_id_t hit;

  // Block state
  logic [7:0] status_r, status_nxt;
  logic [5:0] en_r, en_nxt;
  logic [9:0] col_pos_r, col_pos_nxt;
  logic [7:0] ca_cnt_r, ca_cnt_nxt;
  logic field_ok_r, field_ok_nxt;
  logic irq_r, irq_nxt;
  phase_t phase_r, phase_nxt;

  logic [7:0] set_raw, set_vec, allow, irq_mask;
  logic nfc_ce, nfc_only, ca_fire;

  // Bus decode and answer
  always_comb begin
    hit = reg_hit(wb_req.adr);
    // Ack for one cycle; a held request is not taken again in the cycle of its ack
    ack_nxt = wb_req.cyc & wb_req.stb & ~ack_r;
    rd_done = ack_nxt & ~wb_req.we;
    wr_done = ack_nxt & wb_req.we & wb_req.sel[0];
    st_clr = rd_done && (hit == REG_STATUS);
    cp_clr = rd_done && (hit == REG_COLPOS);
    // Writes to status and position are ignored
    en_wr = wr_done && (hit == REG_ENABLE);
    dat_nxt = dat_r;
    if (rd_done) begin
      unique case (hit)
        REG_STATUS: dat_nxt = {24'h0, status_r};
        REG_ENABLE: dat_nxt = {24'h0, col_pos_r[9:8], en_r}; // [R11]
        REG_COLPOS: dat_nxt = {24'h0, col_pos_r[7:0]}; // [R12]
        REG_NONE: dat_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_rsp = '{ack: ack_r, dat: dat_r};

  // Transfer phase tracking
  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      PH_IDLE: begin
        if (evt.tx_start) begin
          phase_nxt = PH_TX;
        end else if (evt.rx_sof) begin
          phase_nxt = PH_RX;
        end
      end
      PH_TX: begin
        if (evt.tx_done) begin
          phase_nxt = PH_IDLE;
        end
      end
      PH_RX: begin
        if (evt.rx_done) begin
          phase_nxt = PH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      phase_r <= PH_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Wait after collision avoidance
  always_comb begin
    // A fresh ca_done in NFC mode restarts the wait
    ca_cnt_nxt = ca_cnt_r;
    ca_fire = 1'b0;
    if (evt.ca_done && nfc_only) begin
      ca_cnt_nxt = CA_WAIT;
    end else if (ca_cnt_r != 8'h00) begin
      ca_cnt_nxt = ca_cnt_r - 8'h01;
      ca_fire = (ca_cnt_r == 8'h01); // [R7]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ca_cnt_r <= 8'h00;
    end else begin
      ca_cnt_r <= ca_cnt_nxt;
    end
  end

  // Operating mode decode
  always_comb begin
    nfc_ce = (op_mode == OP_NFC) || (op_mode == OP_CARD_EMU);
    nfc_only = (op_mode == OP_NFC);
  end

  // Flags allowed by the current or starting phase
  always_comb begin
    allow = phase_allow(phase_r);
    if (phase_r == PH_IDLE && evt.tx_start) begin
      allow = phase_allow(PH_TX);
    end else if (phase_r == PH_IDLE && evt.rx_sof) begin
      allow = phase_allow(PH_RX);
    end
  end

  // Status event sources
  always_comb begin
    set_raw = 8'h00;
    set_raw[`ST_TX] = evt.tx_start; // [R2]
    set_raw[`ST_RX] = evt.rx_sof; // [R3]
    set_raw[`ST_FIFO] = evt.fifo_cross; // [R4]
    set_raw[`ST_PROTO_ERR] = nfc_ce & evt.proto_err; // [R5]
    set_raw[`ST_SDD] = nfc_ce & evt.sdd_done; // [R5]
    // Field edge seen against last cycle's level
    set_raw[`ST_FIELD] = nfc_ce & (field_ok != field_ok_r); // [R6]
    set_raw[`ST_CA_DONE] = nfc_only & ca_fire; // [R7]
    set_raw[`ST_CA_FAIL] = nfc_only & evt.ca_blocked; // [R8]
    set_vec = set_raw & allow; // [R16]
  end

  // Per-flag sticky bits; set wins over read clear
  generate
    for (genvar i = 0; i < 8; i++) begin : g_flag
      assign status_nxt[i] = set_vec[i] |
        (status_r[i] & ~st_clr); // [R1] [R15]
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      status_r <= `STATUS_RESET; // [R1]
    end else begin
      status_r <= status_nxt;
    end
  end

  // Enable bits
  always_comb begin
    // Only bits 5:0 are writable; 7:6 are position bits
    en_nxt = en_r;
    if (en_wr) begin
      en_nxt = wb_req.dat[5:0]; // [R9] [R10]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      en_r <= `ENABLE_RESET; // [R9] [R10]
    end else begin
      en_r <= en_nxt;
    end
  end

  // Field level seen one cycle earlier
  always_comb begin
    field_ok_nxt = field_ok;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      field_ok_r <= 1'b0;
    end else begin
      field_ok_r <= field_ok_nxt;
    end
  end

  // Interrupt line, held low until a phase ends
  always_comb begin
    // Bits 7 and 6 have no enable and always count
    irq_mask = {2'b11, en_r};
    irq_nxt = (phase_nxt == PH_IDLE) &&
      ((status_nxt & irq_mask) != 8'h00); // [R17] [R2] [R3] [R15]
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Collision or error position
  always_comb begin
    // Chip disable beats capture, capture beats read clear
    col_pos_nxt = col_pos_r;
    if (cp_clr) begin
      col_pos_nxt = `COL_POS_RESET; // [R14]
    end
    if (type_a && evt.col_evt) begin
      col_pos_nxt = col_bit_pos; // [R12] [R11]
    end else if (!type_a && evt.err_evt) begin
      col_pos_nxt = err_bit_pos; // [R13]
    end
    if (!chip_en) begin
      col_pos_nxt = `COL_POS_RESET; // [R14]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      col_pos_r <= `COL_POS_RESET; // [R14]
    end else begin
      col_pos_r <= col_pos_nxt;
    end
  end

  assign irq = irq_r;

endmodule

// ### shared/nfc_irq_cfg.svh
// Offsets, field positions, reset values and timing counts
`ifndef NFC_IRQ_CFG_SVH
`define NFC_IRQ_CFG_SVH

`define IRQ_STATUS_IDX 8'h0c
`define IRQ_ENABLE_IDX 8'h0d
`define COL_POS_IDX 8'h0e

`define ST_TX 7
`define ST_RX 6
`define ST_FIFO 5
`define ST_PROTO_ERR 4
`define ST_SDD 3
`define ST_FIELD 2
`define ST_CA_DONE 1
`define ST_CA_FAIL 0

`define STATUS_RESET 8'h00
`define ENABLE_RESET 6'h3e
`define COL_POS_RESET 10'h000
`define TX_ALLOW 8'ha0
`define RX_ALLOW 8'h40
`define IDLE_ALLOW 8'hff

`define CLK_PERIOD_NS 5
`define CA_WAIT_NS 320
`define CA_WAIT_CYC \
  ((`CA_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### shared/nfc_irq_pkg.sv
// Types shared by the interrupt status block
package nfc_irq_pkg;

  typedef enum logic [1:0] {
    OP_READER,
    OP_NFC,
    OP_CARD_EMU
  } op_mode_t;

  typedef enum logic [1:0] {
    REG_NONE,
    REG_STATUS,
    REG_ENABLE,
    REG_COLPOS
  } reg_id_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic tx_start;
    logic tx_done;
    logic rx_sof;
    logic rx_done;
    logic fifo_cross;
    logic proto_err;
    logic sdd_done;
    logic ca_done;
    logic ca_blocked;
    logic col_evt;
    logic err_evt;
  } nfc_evt_t;

endpackage

// ### test/nfc_irq_sva.sv
// Port assertions for the interrupt status block
`timescale 1ns/100ps
module nfc_irq_sva
  import nfc_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire wb_req_t wb_req,
  input wire wb_rsp_t wb_rsp,
  input wire op_mode_t op_mode,
  input wire logic chip_en,
  input wire logic type_a,
  input wire nfc_evt_t evt,
  input wire logic field_ok,
  input wire logic [9:0] col_bit_pos,
  input wire logic [9:0] err_bit_pos,
  input wire logic irq
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  wire tk = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  wire rd = tk && !wb_req.we;
  wire [31:0] a = wb_req.adr;
  wire q = evt == '0 && op_mode == OP_READER;
  property p_ack; tk |=> wb_rsp.ack ##1 !wb_rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("ack");
  property p_idle; !wb_req.cyc |=> !wb_rsp.ack; endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_tx; evt.tx_start && evt[9:7] == '0 |=> !irq; endproperty
  a_tx: assert property (p_tx) else $error("tx irq");
  property p_rx; evt.rx_sof && !evt.rx_done && !evt.tx_done |=> !irq;
  endproperty
  a_rx: assert property (p_rx) else $error("rx irq");
  property p_txe; evt.tx_start && !tk ##1 evt.tx_done && !tk |=> irq;
  endproperty
  a_txe: assert property (p_txe) else $error("tx end");
  property p_clr; rd && a == 32'h30 && q ##1 q |=> !irq; endproperty
  a_clr: assert property (p_clr) else $error("irq clear");
  property p_cen; !chip_en ##1 rd && a == 32'h38 && !chip_en |=>
    wb_rsp.dat == '0; endproperty
  a_cen: assert property (p_cen) else $error("colpos en");
  property p_hi; rd |=> wb_rsp.dat[31:8] == '0; endproperty
  a_hi: assert property (p_hi) else $error("upper data");
  c_st: cover property (rd && a == 32'h30);
  c_irq: cover property ($rose(irq));
  c_cp: cover property (rd && a == 32'h38);
endmodule

// ### test/host_bus.sv
// Host model issuing single bus cycles
`timescale 1ns/100ps
module host_bus
  import nfc_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire wb_rsp_t wb_rsp,
  output wb_req_t wb_req
);
  initial wb_req = '0;
  task automatic xfer(input logic w, input logic [31:0] a,
      input logic [7:0] d, output logic [7:0] r, output bit ok);
    wb_req_t q;
    int n;
    q = '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
    n = 0;
    @(posedge ref_clk);
    wb_req <= q;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 20);
    ok = wb_rsp.ack === 1'b1;
    r = wb_rsp.dat[7:0];
    // Released lines show the inverse
    wb_req <= {2'b00, ~q[68:0]};
  endtask
endmodule

// ### test/testbench.sv
// Self-checking bench for the interrupt status block
`timescale 1ns/100ps
`include "nfc_irq_cfg.svh"
module testbench import nfc_irq_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic chip_en = 1'b1;
  logic type_a = 1'b0;
  logic field_ok = 1'b0;
  logic irq;
  logic [9:0] col_bit_pos = '0;
  logic [9:0] err_bit_pos = '0;
  op_mode_t op_mode = OP_READER;
  nfc_evt_t evt = '0;
  wb_req_t wb_req;
  wb_rsp_t wb_rsp;
  int fails = 0;
  int samples_checked = 0;
  logic [9:0] q[$];
  logic [31:0] sd = 32'h2d749ed2;
  nfc_irq_status_collision_pos DUT (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wb_req(wb_req),
    .wb_rsp(wb_rsp),
    .op_mode(op_mode),
    .chip_en(chip_en),
    .type_a(type_a),
    .evt(evt),
    .field_ok(field_ok),
    .col_bit_pos(col_bit_pos),
    .err_bit_pos(err_bit_pos),
    .irq(irq)
  );
  host_bus hst (
    .ref_clk(ref_clk),
    .wb_rsp(wb_rsp),
    .wb_req(wb_req)
  );
  initial forever #2.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic acc(logic w, logic [7:0] i, logic [7:0] d,
      logic [7:0] e, string n);
    logic [7:0] r;
    bit ok;
    hst.xfer(w, {22'h0, i, 2'b00}, d, r, ok);
    if (!ok) begin
      fails++;
      finish_test();
    end
    if (!w)
      chk(n, e, r);
  endtask
  task automatic pulse(logic [10:0] e);
    evt <= e;
    @(posedge ref_clk);
  endtask
  initial begin
    logic [7:0] en;
    logic [7:0] e;
    logic [9:0] p;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    acc(1'b0, `IRQ_ENABLE_IDX, 8'h00, 8'h3e, "enable");
    acc(1'b0, `IRQ_STATUS_IDX, 8'h00, 8'h00, "status");
    acc(1'b0, `COL_POS_IDX, 8'h00, 8'h00, "colpos");
    acc(1'b0, 8'h0f, 8'h00, 8'h00, "unmapped");
    pulse(11'h400);
    pulse(11'h200);
    pulse(11'h000);
    chk("irq", 8'h01, {7'h0, irq});
    acc(1'b0, `IRQ_STATUS_IDX, 8'h00, 8'h80, "status");
    chk("irq", 8'h00, {7'h0, irq});
    pulse(11'h400);
    pulse(11'h140);
    pulse(11'h200);
    pulse(11'h000);
    acc(1'b0, `IRQ_STATUS_IDX, 8'h00, 8'ha0, "status");
    op_mode <= OP_NFC;
    pulse(11'h100);
    pulse(11'h060);
    pulse(11'h080);
    pulse(11'h000);
    chk("irq", 8'h01, {7'h0, irq});
    acc(1'b0, `IRQ_STATUS_IDX, 8'h00, 8'h40, "status");
    for (int m = 1; m < 4; m++) begin
      sd = xs(sd);
      en = {2'b00, sd[5:0]};
      e = m == 1 ? 8'h1f : m == 2 ? 8'h1c : 8'h00;
      acc(1'b1, `IRQ_ENABLE_IDX, en, 8'h00, "");
      acc(1'b0, `IRQ_ENABLE_IDX, 8'h00, en, "enable");
      op_mode <= op_mode_t'(2'(m % 3));
      field_ok <= ~field_ok;
      pulse(11'h03c);
      pulse(11'h000);
      repeat (70) @(posedge ref_clk);
      chk("irq", {7'h0, |(e & {2'b11, en[5:0]})}, {7'h0, irq});
      acc(1'b0, `IRQ_STATUS_IDX, 8'h00, e, "status");
    end
    for (int t = 0; t < 2; t++) begin
      sd = xs(sd);
      type_a <= t[0];
      col_bit_pos <= sd[9:0];
      err_bit_pos <= ~sd[9:0];
      q.push_back(t ? sd[9:0] : ~sd[9:0]);
      pulse(11'h003);
      pulse(11'h000);
      p = q.pop_front();
      acc(1'b0, `IRQ_ENABLE_IDX, 8'h00, {p[9:8], en[5:0]}, "colhi");
      acc(1'b0, `COL_POS_IDX, 8'h00, p[7:0], "colpos");
      acc(1'b0, `COL_POS_IDX, 8'h00, 8'h00, "colpos");
    end
    pulse(11'h003);
    pulse(11'h000);
    chip_en <= 1'b0;
    acc(1'b0, `COL_POS_IDX, 8'h00, 8'h00, "colpos");
    chip_en <= 1'b1;
    finish_test();
  end
endmodule
bind nfc_irq_status_collision_pos nfc_irq_sva u_sva (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .wb_req(wb_req),
  .wb_rsp(wb_rsp),
  .op_mode(op_mode),
  .chip_en(chip_en),
  .type_a(type_a),
  .evt(evt),
  .field_ok(field_ok),
  .col_bit_pos(col_bit_pos),
  .err_bit_pos(err_bit_pos),
  .irq(irq)
);
